// file: rtl/iel_cfg.svh
`ifndef IEL_CFG_SVH
`define IEL_CFG_SVH

// ----------------------------------------
// Sizes and timing
// ----------------------------------------
`define IEL_NCH 64
`define IEL_AW 15
`define IEL_LOG_DEPTH 12'hC00
`define IEL_LOG_LAST 12'hBFF
`define IEL_CLK_MHZ 100
`define IEL_TICK_US 1000
`define IEL_BOARD_ID 16'h5A5A

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define IEL_OFF_ID 15'h0000
`define IEL_OFF_CS 15'h0004
`define IEL_OFF_IEN 15'h0008
`define IEL_OFF_VEC 15'h000C
`define IEL_OFF_STAT 15'h0010
`define IEL_OFF_TAG 15'h0014
`define IEL_OFF_MAX 15'h0018
`define IEL_OFF_CNT 15'h001C
`define IEL_OFF_IDX 15'h0020
`define IEL_OFF_REQ 15'h0024
`define IEL_GRP_STATE 11'h003
`define IEL_GRP_CHG 11'h004
`define IEL_GRP_PROLL 11'h005
`define IEL_WIN_DSEL 7'h01
`define IEL_WIN_PCNT 7'h02

// ----------------------------------------
// Field positions
// ----------------------------------------
`define IEL_DS_TIME_MSB 9
`define IEL_DS_AC 10
`define IEL_DS_MODE_LSB 11
`define IEL_DS_PDIR 13
`define IEL_DS_PEN 14
`define IEL_DS_PIE 15
`define IEL_CS_LED 0
`define IEL_CS_TMD 1
`define IEL_CS_RUN 2
`define IEL_CS_STC 3
`define IEL_SRC_CHG 0
`define IEL_SRC_TAG 1
`define IEL_SRC_PUL 2
`define IEL_SRC_EOB 3
`define IEL_SRC_FIRST 4
`define IEL_SRC_MAX 5

// ----------------------------------------
// Reset values and address modifiers
// ----------------------------------------
`define IEL_CS_RST 3'h1
`define IEL_AM_A16_USR 6'h29
`define IEL_AM_A16_SUP 6'h2D
`define IEL_AM_A24_USR 6'h39
`define IEL_AM_A24_SUP 6'h3D

`endif

// file: rtl/iel_pkg.sv
`include "iel_cfg.svh"

package iel_pkg;

	typedef enum logic [1:0] {CD_NONE, CD_RISE, CD_FALL, CD_BOTH} iel_cd_mode_e;

	typedef enum logic {ST_IDLE, ST_SCAN} iel_scan_e;

	typedef struct packed {
		logic read;
		logic write;
		logic [`IEL_AW-1:0] address;
		logic [31:0] writedata;
		logic [3:0] byteenable;
		logic [5:0] addr_mod;
	} iel_bus_req_s;

	typedef struct packed {
		logic strobe;
		logic [2:0] level;
	} iel_iack_s;

	typedef struct packed {
		logic [5:0] chan;
		logic [15:0] tag;
	} iel_entry_s;

endpackage

// file: rtl/iel_top.sv
// Local design decisions: the Avalon-MM slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "iel_cfg.svh"

module iel_top #(
	parameter int P_TICK_CYC = `IEL_TICK_US * `IEL_CLK_MHZ
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	// Field inputs
	input wire logic [`IEL_NCH-1:0] i_field,
	// Access mode straps
	input wire logic i_cfg_short_io,
	input wire logic [1:0] i_cfg_access,
	// Register bus
	input wire iel_pkg::iel_bus_req_s i_bus,
	output logic o_waitrequest,
	output logic [31:0] o_readdata,
	// Interrupter
	input wire iel_pkg::iel_iack_s i_iack,
	output logic o_irq_req,
	output logic [2:0] o_irq_level,
	output logic o_iack_ack,
	output logic [7:0] o_iack_vector,
	// Front panel
	output logic o_fail_led
);

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd, input logic [1:0] be);
		merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	function automatic logic am_ok(input logic [5:0] am, input logic short_io, input logic [1:0] acc);
		logic usr;
		logic sup;
		usr = (am == (short_io ? `IEL_AM_A16_USR : `IEL_AM_A24_USR));
		sup = (am == (short_io ? `IEL_AM_A16_SUP : `IEL_AM_A24_SUP));
		unique case (acc)
			2'h1: am_ok = sup;
			2'h2: am_ok = usr;
			default: am_ok = usr | sup;
		endcase
	endfunction

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [16:0] tick_cnt_q;
	logic tick;
	iel_pkg::iel_scan_e scan_q;
	logic [5:0] ch_q;
	logic [`IEL_NCH-1:0] samp_q, state_q, chg_q, proll_q;
	logic [15:0] dsel_q [`IEL_NCH];
	logic [12:0] dcnt_q [`IEL_NCH];
	logic [15:0] pcnt_q [`IEL_NCH];
	logic [2:0] cs_q;
	logic stc_q;
	logic [5:0] ien_q;
	logic [7:0] vec_q;
	logic [2:0] lvl_q;
	logic [5:0] stat_q;
	logic [15:0] tag_q;
	logic [11:0] max_q, cnt_q, idx_q;
	logic act_q;
	iel_pkg::iel_entry_s log_q [2][`IEL_LOG_DEPTH];
	logic irq_q, ack_q, iack_ack_q;
	logic [7:0] iack_vec_q;
	logic [31:0] rdata_q;
	logic [31:0] rd_val;
	logic req, wr_go, rd_go, acc_ok;
	logic [`IEL_AW-1:0] off;
	logic [15:0] wd16;
	logic [1:0] wbe;
	logic scan_en, cur, smp, differ, accept, match, pulse, pwrap, tag_adv, tag_wrap;
	logic [15:0] sel;
	logic [12:0] t1, need, cnt_nx;
	logic log_wr, req_wr, eob_ev, first_ev, max_ev;
	logic [11:0] wr_addr, cnt_after;
	logic wr_buf;
	logic [5:0] src_ev;

	// ----------------------------------------
	// Bus slave, one wait state
	// ----------------------------------------
	assign req = i_bus.read | i_bus.write;
	assign o_waitrequest = req & ~ack_q;
	assign off = i_bus.address;
	assign acc_ok = am_ok(i_bus.addr_mod, i_cfg_short_io, i_cfg_access);
	// Refused modifiers are still answered so the master never hangs
	assign wr_go = i_bus.write & ack_q & acc_ok;
	assign rd_go = i_bus.read & ~ack_q;
	assign wd16 = i_bus.writedata[15:0];
	assign wbe = i_bus.byteenable[1:0];
	assign o_readdata = rdata_q;

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rdata_q <= 32'h0000_0000;
		end else if (rd_go) begin
			rdata_q <= acc_ok ? rd_val : 32'h0000_0000;
		end
	end

	always_comb begin
		rd_val = 32'h0000_0000;
		if (off[14] && off[13:2] < `IEL_LOG_DEPTH) begin
			// Host sees the buffer not being written
			rd_val = {10'h000, log_q[~act_q][off[13:2]]};
		end else if (off[14:8] == `IEL_WIN_DSEL) begin
			rd_val = {16'h0000, dsel_q[off[7:2]]};
		end else if (off[14:8] == `IEL_WIN_PCNT) begin
			rd_val = {16'h0000, pcnt_q[off[7:2]]};
		end else if (off[14:4] == `IEL_GRP_STATE) begin
			rd_val = {16'h0000, state_q[16*off[3:2] +: 16]};
		end else if (off[14:4] == `IEL_GRP_CHG) begin
			rd_val = {16'h0000, chg_q[16*off[3:2] +: 16]};
		end else if (off[14:4] == `IEL_GRP_PROLL) begin
			rd_val = {16'h0000, proll_q[16*off[3:2] +: 16]};
		end else begin
			unique case (off)
				`IEL_OFF_ID: rd_val = {16'h0000, `IEL_BOARD_ID};
				`IEL_OFF_CS: rd_val = {28'h000_0000, stc_q, cs_q};
				`IEL_OFF_IEN: rd_val = {26'h000_0000, ien_q};
				`IEL_OFF_VEC: rd_val = {21'h00_0000, lvl_q, vec_q};
				`IEL_OFF_STAT: rd_val = {26'h000_0000, stat_q};
				`IEL_OFF_TAG: rd_val = {16'h0000, tag_q};
				`IEL_OFF_MAX: rd_val = {20'h0_0000, max_q};
				`IEL_OFF_CNT: rd_val = {20'h0_0000, cnt_q};
				`IEL_OFF_IDX: rd_val = {20'h0_0000, idx_q};
				default: rd_val = 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cs_q <= `IEL_CS_RST;
			ien_q <= 6'h00;
			vec_q <= 8'h00;
			lvl_q <= 3'h0;
			max_q <= 12'h000;
		end else if (wr_go) begin
			if (off == `IEL_OFF_CS) begin
				cs_q <= 3'(merge16({13'h0000, cs_q}, wd16, wbe));
			end
			if (off == `IEL_OFF_IEN) begin
				ien_q <= 6'(merge16({10'h000, ien_q}, wd16, wbe));
			end
			if (off == `IEL_OFF_VEC) begin
				{lvl_q, vec_q} <= 11'(merge16({5'h00, lvl_q, vec_q}, wd16, wbe));
			end
			if (off == `IEL_OFF_MAX) begin
				max_q <= 12'(merge16({4'h0, max_q}, wd16, wbe));
			end
		end
	end

	// Self-test itself is not modelled; completion is flagged once out of reset
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			stc_q <= 1'b0;
		end else begin
			stc_q <= 1'b1;
		end
	end

	assign o_fail_led = cs_q[`IEL_CS_LED];

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			for (int i = 0; i < `IEL_NCH; i++) begin
				dsel_q[i] <= 16'h0000;
			end
		end else if (wr_go && off[14:8] == `IEL_WIN_DSEL) begin
			dsel_q[off[7:2]] <= merge16(dsel_q[off[7:2]], wd16, wbe);
		end
	end

	// ----------------------------------------
	// Millisecond tick and time tag
	// ----------------------------------------
	assign tick = (tick_cnt_q == 17'(P_TICK_CYC - 1));

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tick_cnt_q <= 17'h0_0000;
		end else begin
			tick_cnt_q <= tick ? 17'h0_0000 : tick_cnt_q + 17'h0_0001;
		end
	end

	assign tag_adv = tick & cs_q[`IEL_CS_RUN];
	assign tag_wrap = tag_adv & (tag_q == 16'hFFFF);

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tag_q <= 16'h0000;
		end else if (wr_go && off == `IEL_OFF_TAG) begin
			tag_q <= merge16(tag_q, wd16, wbe);
		end else if (tag_adv) begin
			tag_q <= tag_q + 16'h0001;
		end
	end

	// ----------------------------------------
	// Channel scan, one channel per cycle
	// ----------------------------------------
	// Serial scan keeps events ordered and lets one log port serve all channels
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			scan_q <= iel_pkg::ST_IDLE;
			ch_q <= 6'h00;
			samp_q <= 64'h0000_0000_0000_0000;
		end else begin
			unique case (scan_q)
				iel_pkg::ST_IDLE: begin
					if (tick) begin
						samp_q <= i_field;
						ch_q <= 6'h00;
						scan_q <= iel_pkg::ST_SCAN;
					end
				end
				iel_pkg::ST_SCAN: begin
					ch_q <= ch_q + 6'h01;
					if (ch_q == 6'h3F) begin
						scan_q <= iel_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	assign scan_en = (scan_q == iel_pkg::ST_SCAN);

	always_comb begin
		sel = dsel_q[ch_q];
		cur = state_q[ch_q];
		smp = samp_q[ch_q];
		differ = scan_en & (cur ^ smp);
		t1 = {3'h0, sel[`IEL_DS_TIME_MSB:0]} + 13'h0001;
		need = (sel[`IEL_DS_AC] & cur & ~smp) ? {t1[10:0], 2'h0} : t1;
		cnt_nx = dcnt_q[ch_q] + 13'h0001;
		accept = differ & (cnt_nx >= need);
		unique case (iel_pkg::iel_cd_mode_e'(sel[`IEL_DS_MODE_LSB +: 2]))
			iel_pkg::CD_RISE: match = accept & smp;
			iel_pkg::CD_FALL: match = accept & ~smp;
			iel_pkg::CD_BOTH: match = accept;
			iel_pkg::CD_NONE: match = 1'b0;
		endcase
		pulse = accept & sel[`IEL_DS_PEN] & (sel[`IEL_DS_PDIR] ? ~smp : smp);
		pwrap = pulse & (pcnt_q[ch_q] == 16'hFFFF) & sel[`IEL_DS_PIE];
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_q <= 64'h0000_0000_0000_0000;
			for (int i = 0; i < `IEL_NCH; i++) begin
				dcnt_q[i] <= 13'h0000;
			end
		end else if (scan_en) begin
			dcnt_q[ch_q] <= (differ && !accept) ? cnt_nx : 13'h0000;
			if (accept) begin
				state_q[ch_q] <= smp;
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			for (int i = 0; i < `IEL_NCH; i++) begin
				pcnt_q[i] <= 16'h0000;
			end
		end else begin
			if (wr_go && off[14:8] == `IEL_WIN_PCNT) begin
				pcnt_q[off[7:2]] <= merge16(pcnt_q[off[7:2]], wd16, wbe);
			end
			// Count wins if the host writes the same channel in the same cycle
			if (pulse) begin
				pcnt_q[ch_q] <= pcnt_q[ch_q] + 16'h0001;
			end
		end
	end

	// Flags are write-one-to-clear; a set in the same cycle wins
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			chg_q <= 64'h0000_0000_0000_0000;
			proll_q <= 64'h0000_0000_0000_0000;
		end else begin
			for (int k = 0; k < 4; k++) begin
				if (wr_go && off == {`IEL_GRP_CHG, 2'(k), 2'h0}) begin
					chg_q[16*k +: 16] <= chg_q[16*k +: 16] & ~wd16;
				end
				if (wr_go && off == {`IEL_GRP_PROLL, 2'(k), 2'h0}) begin
					proll_q[16*k +: 16] <= proll_q[16*k +: 16] & ~wd16;
				end
			end
			if (match) begin
				chg_q[ch_q] <= 1'b1;
			end
			if (pwrap) begin
				proll_q[ch_q] <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Event log
	// ----------------------------------------
	assign log_wr = match;
	assign req_wr = wr_go & (off == `IEL_OFF_REQ);
	// A swap and an event in one cycle: the event opens the fresh buffer
	assign wr_buf = req_wr ? ~act_q : act_q;
	assign wr_addr = req_wr ? 12'h000 : cnt_q;
	assign eob_ev = log_wr & (wr_addr == `IEL_LOG_LAST);
	assign cnt_after = eob_ev ? 12'h000 : wr_addr + 12'h001;
	assign first_ev = log_wr & (wr_addr == 12'h000);
	assign max_ev = log_wr & (max_q != 12'h000) & (cnt_after == max_q);

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			act_q <= 1'b0;
			cnt_q <= 12'h000;
			idx_q <= 12'h000;
		end else begin
			if (req_wr) begin
				act_q <= ~act_q;
				idx_q <= cnt_q;
				cnt_q <= 12'h000;
			end
			if (log_wr) begin
				cnt_q <= cnt_after;
			end
		end
	end

	// Storage has no reset; only written entries are meaningful
	always_ff @(posedge i_ref_clk) begin
		if (log_wr) begin
			log_q[wr_buf][wr_addr] <= '{chan: ch_q, tag: tag_q};
		end
	end

	// ----------------------------------------
	// Interrupter
	// ----------------------------------------
	always_comb begin
		src_ev = 6'h00;
		src_ev[`IEL_SRC_CHG] = match;
		src_ev[`IEL_SRC_TAG] = tag_wrap;
		src_ev[`IEL_SRC_PUL] = pwrap;
		src_ev[`IEL_SRC_EOB] = eob_ev;
		src_ev[`IEL_SRC_FIRST] = first_ev;
		src_ev[`IEL_SRC_MAX] = max_ev;
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			stat_q <= 6'h00;
		end else begin
			if (wr_go && off == `IEL_OFF_STAT) begin
				stat_q <= (stat_q & ~wd16[5:0]) | src_ev;
			end else begin
				stat_q <= stat_q | src_ev;
			end
		end
	end

	// Release on acknowledge: a matching acknowledge drops the request; an enabled event in the same cycle wins
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			irq_q <= 1'b0;
			iack_ack_q <= 1'b0;
			iack_vec_q <= 8'h00;
		end else begin
			iack_ack_q <= 1'b0;
			if (i_iack.strobe && irq_q && i_iack.level == lvl_q) begin
				irq_q <= 1'b0;
				iack_ack_q <= 1'b1;
				iack_vec_q <= vec_q;
			end
			if ((|(src_ev & ien_q)) && lvl_q != 3'h0) begin
				irq_q <= 1'b1;
			end
			if (lvl_q == 3'h0) begin
				irq_q <= 1'b0;
			end
		end
	end

	assign o_irq_req = irq_q;
	assign o_irq_level = lvl_q;
	assign o_iack_ack = iack_ack_q;
	assign o_iack_vector = iack_vec_q;

endmodule

`default_nettype wire

// file: test/iel_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module iel_host_model #(
	parameter int P_DELAY = 4
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	// Request from the device
	input wire logic i_irq_req,
	input wire logic [2:0] i_irq_level,
	// Fault control
	input wire logic i_bad_level,
	// Acknowledge cycle
	output var iel_pkg::iel_iack_s o_iack
);
	// ----------------------------------------
	// Handler latency
	// ----------------------------------------
	int wait_q;

	// A refused acknowledge is retried, as a polling handler would
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wait_q <= 0;
		end else if (!i_irq_req || o_iack.strobe) begin
			wait_q <= 0;
		end else begin
			wait_q <= wait_q + 1;
		end
	end

	// ----------------------------------------
	// Acknowledge strobe
	// ----------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_iack <= '0;
		end else if (i_irq_req && wait_q == P_DELAY && !o_iack.strobe) begin
			o_iack.strobe <= 1'b1;
			o_iack.level <= i_bad_level ? ~i_irq_level : i_irq_level;
		end else begin
			o_iack.strobe <= 1'b0;
			// Idle level moves every cycle so nothing leans on a stale value
			o_iack.level <= ~o_iack.level;
		end
	end
endmodule

`default_nettype wire

// file: test/iel_top_sva.sv
`timescale 1ns/100ps
`default_nettype none

module iel_top_sva #(
	parameter int P_TICK_CYC = 100
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	// Register bus
	input wire iel_pkg::iel_bus_req_s i_bus,
	input wire logic o_waitrequest,
	input wire logic [31:0] o_readdata,
	// Interrupter
	input wire iel_pkg::iel_iack_s i_iack,
	input wire logic o_irq_req,
	input wire logic [2:0] o_irq_level,
	input wire logic o_iack_ack,
	input wire logic [7:0] o_iack_vector
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	logic req;
	logic hit;
	assign req = i_bus.read | i_bus.write;
	assign hit = i_iack.strobe & o_irq_req & (i_iack.level == o_irq_level);

	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);

	// ----------------------------------------
	// Bus and interrupter relations
	// ----------------------------------------
	a_wait_one_state: assert property (req && o_waitrequest |=> !o_waitrequest || !req)
		else $error("bus access not answered after one wait state");
	a_wait_rearm: assert property (req && !o_waitrequest |=> o_waitrequest || !req)
		else $error("held request answered without a new wait state");
	a_idle_no_wait: assert property (!req |-> !o_waitrequest)
		else $error("waitrequest high without a request");
	a_read_data_hold: assert property ($changed(o_readdata) |-> $past(i_bus.read))
		else $error("read data changed without a read");
	a_iack_answer: assert property (hit |=> o_iack_ack)
		else $error("matching acknowledge not answered");
	a_no_stray_ack: assert property (!hit |=> !o_iack_ack)
		else $error("acknowledge answered without a match");
	a_vector_hold: assert property ($changed(o_iack_vector) |-> o_iack_ack)
		else $error("vector changed outside an acknowledge");
	a_level_zero_off: assert property (o_irq_level == 3'h0 && $past(o_irq_level) == 3'h0 |-> !o_irq_req)
		else $error("request raised with level zero");
	a_irq_held: assert property (o_irq_req && !hit |=> o_irq_req || o_irq_level == 3'h0)
		else $error("request dropped before acknowledge");
endmodule

bind iel_top iel_top_sva #(.P_TICK_CYC(P_TICK_CYC)) u_sva (
	.i_ref_clk(i_ref_clk),
	.i_rst_b(i_rst_b),
	.i_bus(i_bus),
	.o_waitrequest(o_waitrequest),
	.o_readdata(o_readdata),
	.i_iack(i_iack),
	.o_irq_req(o_irq_req),
	.o_irq_level(o_irq_level),
	.o_iack_ack(o_iack_ack),
	.o_iack_vector(o_iack_vector)
);

`default_nettype wire

// file: test/isolated_input_event_logger_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "iel_cfg.svh"

module isolated_input_event_logger_tb;
	// ----------------------------------------
	// Stimulus and observation
	// ----------------------------------------
	logic ref_clk;
	logic rst_b;
	logic [63:0] field;
	logic short_io;
	logic [1:0] access;
	logic bad_level;
	logic [5:0] am_sel;
	iel_pkg::iel_bus_req_s bus_req;
	iel_pkg::iel_iack_s iack;
	logic o_waitrequest;
	logic [31:0] o_readdata;
	logic o_irq_req;
	logic [2:0] o_irq_level;
	logic o_iack_ack;
	logic [7:0] o_iack_vector;
	logic fail_led;
	logic [31:0] d;
	int num_errors;
	int n_compared;
	int cyc;
	logic [14:0] zero_regs [8] = '{`IEL_OFF_IEN, `IEL_OFF_VEC, `IEL_OFF_STAT, `IEL_OFF_TAG,
		`IEL_OFF_MAX, `IEL_OFF_CNT, `IEL_OFF_IDX, 15'h0028};

	iel_top #(.P_TICK_CYC(100)) dut (
		.i_ref_clk(ref_clk),
		.i_rst_b(rst_b),
		.i_field(field),
		.i_cfg_short_io(short_io),
		.i_cfg_access(access),
		.i_bus(bus_req),
		.o_waitrequest(o_waitrequest),
		.o_readdata(o_readdata),
		.i_iack(iack),
		.o_irq_req(o_irq_req),
		.o_irq_level(o_irq_level),
		.o_iack_ack(o_iack_ack),
		.o_iack_vector(o_iack_vector),
		.o_fail_led(fail_led)
	);

	iel_host_model #(.P_DELAY(6)) host (
		.i_ref_clk(ref_clk),
		.i_rst_b(rst_b),
		.i_irq_req(o_irq_req),
		.i_irq_level(o_irq_level),
		.i_bad_level(bad_level),
		.o_iack(iack)
	);

	always #5 ref_clk = ~ref_clk;

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic xfer(input logic w, input logic [14:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge ref_clk);
		bus_req.read <= !w;
		bus_req.write <= w;
		bus_req.address <= a;
		bus_req.writedata <= wd;
		bus_req.byteenable <= 4'h3;
		bus_req.addr_mod <= am_sel;
		// Looked at on the edge itself, so the values seen are those that stood before it
		do @(posedge ref_clk); while (o_waitrequest !== 1'b0);
		rd = o_readdata;
		bus_req.read <= 1'b0;
		bus_req.write <= 1'b0;
	endtask

	task automatic wr(input logic [14:0] a, input logic [31:0] wd);
		logic [31:0] unused;
		xfer(1'b1, a, wd, unused);
	endtask

	task automatic rd(input logic [14:0] a);
		xfer(1'b0, a, 32'h0000_0000, d);
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
		n_compared++;
		if (!(got >= lo && got <= hi)) begin
			num_errors++;
			$display("CHECK FAILED at %0t: %h outside %h..%h", $time, got, lo, hi);
		end
	endtask

	task automatic wait_ack();
		do @(negedge ref_clk); while (o_iack_ack !== 1'b1);
	endtask

	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Ceiling well above the few thousand cycles the tests need
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			num_errors++;
			$display("CHECK FAILED at %0t: timeout", $time);
			test_done();
		end
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		ref_clk = 1'b0;
		rst_b = 1'b0;
		field = '0;
		short_io = 1'b0;
		access = 2'b00;
		bad_level = 1'b0;
		am_sel = `IEL_AM_A24_USR;
		bus_req = '0;
		num_errors = 0;
		n_compared = 0;
		cyc = 0;
		repeat (12) @(posedge ref_clk);
		rst_b <= 1'b1;
		rd(`IEL_OFF_CS); check(d, 32'h0000_0009);
		check(fail_led, 32'h0000_0001);
		foreach (zero_regs[i]) begin
			rd(zero_regs[i]); check(d, 32'h0000_0000);
		end
		repeat (300) @(posedge ref_clk);
		rd(`IEL_OFF_TAG); check(d, 32'h0000_0000);
		$display("test reset done");

		wr(`IEL_OFF_CS, 32'h0000_0005);
		wr(`IEL_OFF_TAG, 32'h0000_FFFE);
		repeat (500) @(posedge ref_clk);
		rd(`IEL_OFF_TAG); check_rng(d[15:0], 16'h0002, 16'h0005);
		rd(`IEL_OFF_STAT); check(d & 32'h0000_0002, 32'h0000_0002);
		wr(`IEL_OFF_TAG, 32'h0000_1000);
		$display("test time tag done");

		wr(15'h0100, 32'h0000_4802);
		field[0] <= 1'b1;
		repeat (100) @(posedge ref_clk);
		rd(15'h0030); check(d & 32'h0000_0001, 32'h0000_0000);
		repeat (400) @(posedge ref_clk);
		rd(15'h0030); check(d & 32'h0000_0001, 32'h0000_0001);
		rd(`IEL_OFF_CNT); check(d, 32'h0000_0001);
		rd(15'h0200); check(d, 32'h0000_0001);
		field[0] <= 1'b0;
		repeat (500) @(posedge ref_clk);
		rd(`IEL_OFF_CNT); check(d, 32'h0000_0001);
		rd(15'h0200); check(d, 32'h0000_0001);
		wr(`IEL_OFF_REQ, 32'h0000_0000);
		rd(`IEL_OFF_IDX); check(d, 32'h0000_0001);
		rd(`IEL_OFF_CNT); check(d, 32'h0000_0000);
		rd(15'h4000); check(d[21:16], 32'h0000_0000);
		check_rng(d[15:0], 16'h1000, 16'h100A);
		wr(`IEL_OFF_MAX, 32'h0000_0002);
		wr(`IEL_OFF_STAT, 32'h0000_003F);
		$display("test log done");

		wr(`IEL_OFF_IEN, 32'h0000_0001);
		wr(`IEL_OFF_VEC, 32'h0000_035C);
		wr(15'h0104, 32'h0000_1800);
		field[1] <= 1'b1;
		wait_ack();
		check(o_iack_vector, 32'h0000_005C);
		check(o_irq_level, 32'h0000_0003);
		check(o_irq_req, 32'h0000_0000);
		@(posedge ref_clk);
		bad_level <= 1'b1;
		field[1] <= 1'b0;
		repeat (300) @(posedge ref_clk);
		check(o_irq_req, 32'h0000_0001);
		bad_level <= 1'b0;
		wait_ack();
		check(o_iack_vector, 32'h0000_005C);
		wr(`IEL_OFF_VEC, 32'h0000_005C);
		field[1] <= 1'b1;
		repeat (300) @(posedge ref_clk);
		check(o_irq_req, 32'h0000_0000);
		rd(`IEL_OFF_STAT); check(d & 32'h0000_0031, 32'h0000_0031);
		$display("test interrupt done");

		wr(`IEL_OFF_STAT, 32'h0000_003F);
		wr(`IEL_OFF_IEN, 32'h0000_0004);
		wr(`IEL_OFF_VEC, 32'h0000_0266);
		wr(15'h0208, 32'h0000_FFFF);
		wr(15'h0108, 32'h0000_FC00);
		field[2] <= 1'b1;
		repeat (300) @(posedge ref_clk);
		rd(15'h0208); check(d, 32'h0000_FFFF);
		field[2] <= 1'b0;
		repeat (200) @(posedge ref_clk);
		rd(15'h0030); check(d & 32'h0000_0004, 32'h0000_0004);
		wait_ack();
		check(o_iack_vector, 32'h0000_0066);
		rd(15'h0208); check(d, 32'h0000_0000);
		rd(15'h0050); check(d & 32'h0000_0004, 32'h0000_0004);
		$display("test pulse done");

		access <= 2'b01;
		rd(`IEL_OFF_ID); check(d, 32'h0000_0000);
		am_sel <= `IEL_AM_A24_SUP;
		rd(`IEL_OFF_ID); check(d, {16'h0000, `IEL_BOARD_ID});
		short_io <= 1'b1;
		access <= 2'b10;
		am_sel <= `IEL_AM_A16_USR;
		rd(`IEL_OFF_ID); check(d, {16'h0000, `IEL_BOARD_ID});
		am_sel <= `IEL_AM_A16_SUP;
		rd(`IEL_OFF_ID); check(d, 32'h0000_0000);
		am_sel <= `IEL_AM_A16_USR;
		wr(`IEL_OFF_CS, 32'h0000_0004);
		rd(`IEL_OFF_CS); check(d, 32'h0000_000C);
		check(fail_led, 32'h0000_0000);
		$display("test access done");

		// Reset in mid-run must bring back the CS, TAG and IEN defaults and the fail LED
		rst_b <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rst_b <= 1'b1;
		rd(`IEL_OFF_CS); check(d, 32'h0000_0009);
		check(fail_led, 32'h0000_0001);
		rd(`IEL_OFF_TAG); check(d, 32'h0000_0000);
		rd(`IEL_OFF_IEN); check(d, 32'h0000_0000);
		$display("test restart done");
		test_done();
	end
endmodule

`default_nettype wire
